// file: hdl/sdsv_cfg.svh
// Register map, reset values and timing constants of the spindle drive supervision block
`ifndef SDSV_CFG_SVH
`define SDSV_CFG_SVH
`define SDSV_CLK_HZ 50000000
`define SDSV_TICK_US 1000
`define SDSV_US_PER_S 1000000
`define SDSV_MS_PER_S 1000
`define SDSV_NPAR 20
`define SDSV_OFF_SETPOINT 8'h50
`define SDSV_OFF_CTRL 8'h54
`define SDSV_OFF_STATUS 8'h58
`define SDSV_OFF_MASK 8'h5c
`define SDSV_IDX_CUSHION 5'h00
`define SDSV_IDX_HYST 5'h01
`define SDSV_IDX_REACH 5'h02
`define SDSV_IDX_TL2 5'h03
`define SDSV_IDX_SPEED_DEVIATION_ALARM_TIMER 5'h09
`define SDSV_IDX_EXC 5'h0a
`define SDSV_IDX_THR 5'h0b
`define SDSV_IDX_RSVA 5'h0c
`define SDSV_IDX_MKT 5'h0d
`define SDSV_IDX_POST_CHANGEOVER_LIMIT_TIME 5'h0e
`define SDSV_IDX_POST_CHANGEOVER_LIMIT_VALUE 5'h0f
`define SDSV_IDX_RSVB 5'h10
`define SDSV_IDX_OLT 5'h11
`define SDSV_IDX_OLL 5'h12
`define SDSV_IDX_GAIN 5'h13
`define SDSV_RST_CUSHION 16'h0000
`define SDSV_RST_HYST 16'h001e
`define SDSV_RST_REACH 16'h000f
`define SDSV_RST_TL2 16'h0014
`define SDSV_RST_TL3 16'h001e
`define SDSV_RST_TL4 16'h0028
`define SDSV_RST_TL5 16'h0032
`define SDSV_RST_TL6 16'h003c
`define SDSV_RST_TL7 16'h0046
`define SDSV_RST_SPEED_DEVIATION_ALARM_TIMER 16'h000c
`define SDSV_RST_EXC 16'h0032
`define SDSV_RST_THR 16'h0007
`define SDSV_RST_MKT 16'h0096
`define SDSV_RST_POST_CHANGEOVER_LIMIT_TIME 16'h01f4
`define SDSV_RST_POST_CHANGEOVER_LIMIT_VALUE 16'h004b
`define SDSV_RST_OLT 16'h003c
`define SDSV_RST_OLL 16'h006e
`define SDSV_RST_GAIN 16'h0064
`define SDSV_RST_SETPOINT 16'h0000
`define SDSV_THR_ZERO 16'h000c
`define SDSV_FULL_PCT 16'h0064
`define SDSV_PCT_DIV 32'h00000064
`define SDSV_ST_DEV 0
`define SDSV_ST_OL 1
`define SDSV_ST_CHG 2
`define SDSV_ST_DET 3
`define SDSV_CTRL_TL_LSB 0
`define SDSV_CTRL_TL_MSB 1
`define SDSV_CTRL_ALM_CLR 2
`define SDSV_TLMODE_TWO 2'h1
`define SDSV_TLMODE_THREE 2'h2
`endif

// file: hdl/sdsv_pkg.sv
// Types shared by the spindle drive supervision block
package sdsv_pkg;
  // Machine control pins, all asynchronous to CLK
  typedef struct packed {
    logic chg_req;
    logic tl3;
    logic tl2;
    logic tl1;
  } sdsv_pins_t;
  // Supervision flags toward the drive
  typedef struct packed {
    logic shutoff;
    logic accel;
    logic reach;
    logic detect;
  } sdsv_flags_t;
  // Winding changeover sequence, Gray from idle to limit; the return from limit to idle flips both bits
  typedef enum logic [1:0] {
    SDSV_CHG_IDLE = 2'h0,
    SDSV_CHG_SHUT = 2'h1,
    SDSV_CHG_LIMIT = 2'h3
  } sdsv_chg_t;
endpackage

// file: hdl/sdsv_top.sv
// Spindle drive supervision: parameter registers on AXI4-Lite, speed, torque and alarm logic
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "sdsv_cfg.svh"
module sdsv_top #(
  parameter int MS_CYCLES = `SDSV_CLK_HZ / `SDSV_US_PER_S * `SDSV_TICK_US,
  parameter int MS_PER_S = `SDSV_MS_PER_S
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire sdsv_pkg::sdsv_pins_t PINS,
  input wire logic [15:0] SPEED_CMD,
  input wire logic [15:0] SPEED_ACT,
  input wire logic [15:0] LOAD_PCT,
  input wire logic [15:0] EXC_REQ,
  input wire logic [15:0] BASE_GAIN,
  output logic [15:0] SPEED_CMD_OUT,
  output sdsv_pkg::sdsv_flags_t FLAGS,
  output logic [15:0] TORQUE_LIMIT,
  output logic [15:0] CURRENT_LIMIT,
  output logic [15:0] EXC_RATE,
  output logic [15:0] TOP_GAIN,
  output logic DEV_ALARM,
  output logic OL_ALARM,
  output logic IRQ
);
  logic [15:0] par_q [0:`SDSV_NPAR-1];
  logic [15:0] setpoint_q;
  logic [1:0] tl_mode_q;
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic alm_clr;
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic wr_go;
  logic [4:0] wr_idx;
  logic wr_par;
  sdsv_pkg::sdsv_pins_t pin_m_q;
  sdsv_pkg::sdsv_pins_t pin_s_q;
  logic chg_prev_q;
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [15:0] s_cnt_q;
  logic s_tick;

  // Standard settings; reserved slots and unnamed torque slots come from here
  function automatic logic [15:0] rst_val(input logic [4:0] idx);
    case (idx)
      5'h00: rst_val = `SDSV_RST_CUSHION;
      5'h01: rst_val = `SDSV_RST_HYST;
      5'h02: rst_val = `SDSV_RST_REACH;
      5'h03: rst_val = `SDSV_RST_TL2;
      5'h04: rst_val = `SDSV_RST_TL3;
      5'h05: rst_val = `SDSV_RST_TL4;
      5'h06: rst_val = `SDSV_RST_TL5;
      5'h07: rst_val = `SDSV_RST_TL6;
      5'h08: rst_val = `SDSV_RST_TL7;
      5'h09: rst_val = `SDSV_RST_SPEED_DEVIATION_ALARM_TIMER;
      5'h0a: rst_val = `SDSV_RST_EXC;
      5'h0b: rst_val = `SDSV_RST_THR;
      5'h0d: rst_val = `SDSV_RST_MKT;
      5'h0e: rst_val = `SDSV_RST_POST_CHANGEOVER_LIMIT_TIME;
      5'h0f: rst_val = `SDSV_RST_POST_CHANGEOVER_LIMIT_VALUE;
      5'h11: rst_val = `SDSV_RST_OLT;
      5'h12: rst_val = `SDSV_RST_OLL;
      5'h13: rst_val = `SDSV_RST_GAIN;
      default: rst_val = 16'h0000;
    endcase
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // AXI write side: address and data taken independently, one at a time
  assign wr_go = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_idx = aw_addr_q[6:2];
  assign wr_par = (aw_addr_q < `SDSV_OFF_SETPOINT) && (aw_addr_q[1:0] == 2'h0);
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY;
      S_AXI_WREADY <= !w_have_q && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_par || aw_addr_q == `SDSV_OFF_SETPOINT || aw_addr_q == `SDSV_OFF_CTRL ||
                        aw_addr_q == `SDSV_OFF_STATUS || aw_addr_q == `SDSV_OFF_MASK) ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // a write lands in the live register, used on the next cycle; writes to the two reserved slots are dropped
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < `SDSV_NPAR; i++) begin
        par_q[i] <= rst_val(5'(i));
      end
    end else if (wr_go && wr_par && wr_idx != `SDSV_IDX_RSVA && wr_idx != `SDSV_IDX_RSVB) begin
      par_q[wr_idx] <= merge(par_q[wr_idx], w_data_q, w_strb_q);
    end
  end

  // Setpoint, torque input assignment and mask
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      setpoint_q <= `SDSV_RST_SETPOINT;
      tl_mode_q <= 2'h0;
      mask_q <= 4'h0;
    end else if (wr_go) begin
      if (aw_addr_q == `SDSV_OFF_SETPOINT) setpoint_q <= merge(setpoint_q, w_data_q, w_strb_q);
      if (aw_addr_q == `SDSV_OFF_CTRL && w_strb_q[0]) tl_mode_q <= w_data_q[`SDSV_CTRL_TL_MSB:`SDSV_CTRL_TL_LSB];
      if (aw_addr_q == `SDSV_OFF_MASK && w_strb_q[0]) mask_q <= w_data_q[3:0];
    end
  end
  assign alm_clr = wr_go && aw_addr_q == `SDSV_OFF_CTRL && w_strb_q[0] && w_data_q[`SDSV_CTRL_ALM_CLR];

  // AXI read side: data one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'h0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'h0;
        if (S_AXI_ARADDR < `SDSV_OFF_SETPOINT && S_AXI_ARADDR[1:0] == 2'h0) begin
          S_AXI_RDATA <= {16'h0000, par_q[S_AXI_ARADDR[6:2]]};
        end else begin
          case (S_AXI_ARADDR)
            `SDSV_OFF_SETPOINT: S_AXI_RDATA <= {16'h0000, setpoint_q};
            `SDSV_OFF_CTRL: S_AXI_RDATA <= {30'h0, tl_mode_q};
            `SDSV_OFF_STATUS: S_AXI_RDATA <= {28'h0000000, status_q};
            `SDSV_OFF_MASK: S_AXI_RDATA <= {28'h0000000, mask_q};
            default: begin
              S_AXI_RDATA <= 32'h00000000;
              S_AXI_RRESP <= 2'h2;
            end
          endcase
        end
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      chg_prev_q <= 1'b0;
    end else begin
      pin_m_q <= PINS;
      pin_s_q <= pin_m_q;
      chg_prev_q <= pin_s_q.chg_req;
    end
  end

  // Millisecond and second enables
  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
  assign s_tick = ms_tick && (s_cnt_q == 16'(MS_PER_S - 1));
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ms_cnt_q <= 32'h00000000;
      s_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
      if (s_tick) s_cnt_q <= 16'h0000;
      else if (ms_tick) s_cnt_q <= s_cnt_q + 16'h0001;
    end
  end

  // step grows by the cushion value each ms, so a small value eases in slowly
  logic [15:0] step_q;
  logic [15:0] cmd_gap;
  logic [16:0] step_sum;
  logic [15:0] step_d;
  assign cmd_gap = (SPEED_CMD >= SPEED_CMD_OUT) ? SPEED_CMD - SPEED_CMD_OUT : SPEED_CMD_OUT - SPEED_CMD;
  assign step_sum = {1'b0, step_q} + {1'b0, par_q[`SDSV_IDX_CUSHION]};
  assign step_d = (step_sum > {1'b0, cmd_gap}) ? cmd_gap : step_sum[15:0];
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      step_q <= 16'h0000;
      SPEED_CMD_OUT <= 16'h0000;
    end else if (par_q[`SDSV_IDX_CUSHION] == 16'h0000) begin
      step_q <= 16'h0000;
      SPEED_CMD_OUT <= SPEED_CMD;
    end else if (ms_tick) begin
      step_q <= (cmd_gap == 16'h0000) ? 16'h0000 : step_d;
      SPEED_CMD_OUT <= (SPEED_CMD >= SPEED_CMD_OUT) ? SPEED_CMD_OUT + step_d : SPEED_CMD_OUT - step_d;
    end
  end

  // Speed comparisons against the setpoint and the commanded speed
  logic [15:0] act_dev;
  logic [31:0] dev_scaled;
  logic [31:0] reach_win;
  logic [15:0] thr_eff;
  logic [16:0] rel_lvl;
  assign act_dev = (SPEED_ACT >= SPEED_CMD) ? SPEED_ACT - SPEED_CMD : SPEED_CMD - SPEED_ACT;
  assign dev_scaled = {16'h0000, act_dev} * `SDSV_PCT_DIV;
  assign reach_win = {16'h0000, par_q[`SDSV_IDX_REACH]} * {16'h0000, SPEED_CMD};
  // zero threshold is read as twelve
  assign thr_eff = (par_q[`SDSV_IDX_THR] == 16'h0000) ? `SDSV_THR_ZERO : par_q[`SDSV_IDX_THR];
  assign rel_lvl = {1'b0, SPEED_ACT} + {1'b0, par_q[`SDSV_IDX_HYST]};
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      FLAGS.detect <= 1'b0;
      FLAGS.reach <= 1'b0;
      FLAGS.accel <= 1'b0;
    end else begin
      // set at the setpoint, release only a hysteresis width below it
      if (SPEED_ACT >= setpoint_q) FLAGS.detect <= 1'b1;
      else if (rel_lvl < {1'b0, setpoint_q}) FLAGS.detect <= 1'b0;
      // reach while deviation stays inside the window
      FLAGS.reach <= dev_scaled <= reach_win;
      // ramp judged from the gap between command and smoothed command
      FLAGS.accel <= cmd_gap > thr_eff;
    end
  end

  logic [2:0] tl_in;
  logic [15:0] tl_d;
  assign tl_in = {pin_s_q.tl3, pin_s_q.tl2, pin_s_q.tl1};
  always_comb begin
    tl_d = `SDSV_FULL_PCT;
    if (tl_mode_q == `SDSV_TLMODE_TWO || tl_mode_q == `SDSV_TLMODE_THREE) begin
      if (tl_in[1:0] == 2'h2) tl_d = par_q[`SDSV_IDX_TL2];
      if (tl_in[1:0] == 2'h3) tl_d = par_q[`SDSV_IDX_TL2 + 5'h01];
    end
    if (tl_mode_q == `SDSV_TLMODE_THREE && tl_in[2]) begin
      tl_d = par_q[`SDSV_IDX_TL2 + 5'(tl_in) - 5'h02];
    end
  end

  // excitation floor; gain at top speed
  logic [31:0] gain_prod;
  assign gain_prod = {16'h0000, BASE_GAIN} * {16'h0000, par_q[`SDSV_IDX_GAIN]};
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      TORQUE_LIMIT <= `SDSV_FULL_PCT;
      EXC_RATE <= 16'h0000;
      TOP_GAIN <= 16'h0000;
    end else begin
      TORQUE_LIMIT <= tl_d;
      EXC_RATE <= (EXC_REQ < par_q[`SDSV_IDX_EXC]) ? par_q[`SDSV_IDX_EXC] : EXC_REQ;
      TOP_GAIN <= 16'(gain_prod / `SDSV_PCT_DIV);
    end
  end

  // Winding changeover sequence; a request during a sequence is ignored
  sdsv_pkg::sdsv_chg_t chg_q;
  logic [15:0] chg_ms_q;
  logic chg_done;
  assign chg_done = (chg_q == sdsv_pkg::SDSV_CHG_LIMIT) && ms_tick &&
                    (chg_ms_q + 16'h0001 >= par_q[`SDSV_IDX_POST_CHANGEOVER_LIMIT_TIME]);
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      chg_q <= sdsv_pkg::SDSV_CHG_IDLE;
      chg_ms_q <= 16'h0000;
    end else begin
      case (chg_q)
        sdsv_pkg::SDSV_CHG_IDLE: begin
          chg_ms_q <= 16'h0000;
          if (pin_s_q.chg_req && !chg_prev_q) chg_q <= sdsv_pkg::SDSV_CHG_SHUT;
        end
        // hold the power stage off for the shut-off time
        sdsv_pkg::SDSV_CHG_SHUT: begin
          if (ms_tick) begin
            chg_ms_q <= chg_ms_q + 16'h0001;
            // One tick past the setting, so a partial first ms never cuts it short
            if (chg_ms_q + 16'h0001 > par_q[`SDSV_IDX_MKT]) begin
              chg_ms_q <= 16'h0000;
              chg_q <= (par_q[`SDSV_IDX_POST_CHANGEOVER_LIMIT_TIME] == 16'h0000) ? sdsv_pkg::SDSV_CHG_IDLE : sdsv_pkg::SDSV_CHG_LIMIT;
            end
          end
        end
        // current cap for the limit period, then normal
        sdsv_pkg::SDSV_CHG_LIMIT: begin
          if (ms_tick) chg_ms_q <= chg_ms_q + 16'h0001;
          if (chg_done) chg_q <= sdsv_pkg::SDSV_CHG_IDLE;
        end
        default: chg_q <= sdsv_pkg::SDSV_CHG_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      FLAGS.shutoff <= 1'b0;
      CURRENT_LIMIT <= `SDSV_FULL_PCT;
    end else begin
      FLAGS.shutoff <= chg_q == sdsv_pkg::SDSV_CHG_SHUT;
      CURRENT_LIMIT <= (chg_q == sdsv_pkg::SDSV_CHG_LIMIT) ? par_q[`SDSV_IDX_POST_CHANGEOVER_LIMIT_VALUE] : `SDSV_FULL_PCT;
    end
  end

  // Alarm timers in seconds; alarms latch until cleared, a live cause wins
  logic [15:0] dev_s_q;
  logic [15:0] ol_s_q;
  logic dev_hit;
  logic ol_hit;
  logic ol_over;
  assign ol_over = LOAD_PCT > par_q[`SDSV_IDX_OLL];
  // persistence of deviation counted against the timer value
  assign dev_hit = !FLAGS.reach && (dev_s_q >= par_q[`SDSV_IDX_SPEED_DEVIATION_ALARM_TIMER]);
  // overload time integrates up above the level, down at or below it
  assign ol_hit = ol_over && (ol_s_q >= par_q[`SDSV_IDX_OLT]);
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      dev_s_q <= 16'h0000;
      ol_s_q <= 16'h0000;
      DEV_ALARM <= 1'b0;
      OL_ALARM <= 1'b0;
    end else begin
      if (FLAGS.reach) dev_s_q <= 16'h0000;
      else if (s_tick && dev_s_q != 16'hffff) dev_s_q <= dev_s_q + 16'h0001;
      if (s_tick && ol_over && ol_s_q != 16'hffff) ol_s_q <= ol_s_q + 16'h0001;
      else if (s_tick && !ol_over && ol_s_q != 16'h0000) ol_s_q <= ol_s_q - 16'h0001;
      if (dev_hit) DEV_ALARM <= 1'b1;
      else if (alm_clr) DEV_ALARM <= 1'b0;
      if (ol_hit) OL_ALARM <= 1'b1;
      else if (alm_clr) OL_ALARM <= 1'b0;
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  logic [3:0] evt;
  logic det_prev_q;
  logic [3:0] clr;
  assign evt = {FLAGS.detect && !det_prev_q, chg_done, ol_hit && !OL_ALARM, dev_hit && !DEV_ALARM};
  assign clr = (wr_go && aw_addr_q == `SDSV_OFF_STATUS && w_strb_q[0]) ? w_data_q[3:0] : 4'h0;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      status_q <= 4'h0;
      det_prev_q <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      det_prev_q <= FLAGS.detect;
      status_q <= (status_q & ~clr) | evt;
      IRQ <= |(((status_q & ~clr) | evt) & mask_q);
    end
  end
endmodule

// file: dv/sdsv_asserts.sv
// Port-level checker of the spindle drive supervision block
`timescale 1ns/100ps
module sdsv_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire sdsv_pkg::sdsv_pins_t PINS,
  input wire logic [15:0] SPEED_CMD,
  input wire logic [15:0] SPEED_ACT,
  input wire logic [15:0] EXC_REQ,
  input wire logic [15:0] BASE_GAIN,
  input wire logic [15:0] SPEED_CMD_OUT,
  input wire sdsv_pkg::sdsv_flags_t FLAGS,
  input wire logic [15:0] TORQUE_LIMIT,
  input wire logic [15:0] CURRENT_LIMIT,
  input wire logic [15:0] EXC_RATE,
  input wire logic [15:0] TOP_GAIN,
  input wire logic DEV_ALARM,
  input wire logic OL_ALARM
);
  // One clock domain, so one clocking and one disable
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_wr_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write answer repeated");
  property p_exc_floor; 1'b1 |=> EXC_RATE >= $past(EXC_REQ); endproperty
  a_exc_floor: assert property (p_exc_floor) else $error("excitation below request");
  // Range never exceeds 100 percent here, so twice the command is outside it
  property p_reach_out; SPEED_ACT > {SPEED_CMD, 1'b0} |=> !FLAGS.reach; endproperty
  a_reach_out: assert property (p_reach_out) else $error("reach with large deviation");
  property p_dev_cause; $rose(DEV_ALARM) |-> !FLAGS.reach; endproperty
  a_dev_cause: assert property (p_dev_cause) else $error("deviation alarm while in reach");
  property p_gain_cap; 1'b1 |=> TOP_GAIN <= $past(BASE_GAIN); endproperty
  a_gain_cap: assert property (p_gain_cap) else $error("top gain above base gain");
  property p_accel_flat; SPEED_CMD == SPEED_CMD_OUT |=> !FLAGS.accel; endproperty
  a_accel_flat: assert property (p_accel_flat) else $error("accel with no gap");
  property p_cush_hold; SPEED_CMD == SPEED_CMD_OUT |=> SPEED_CMD_OUT == $past(SPEED_CMD); endproperty
  a_cush_hold: assert property (p_cush_hold) else $error("cushion moved with no gap");
  // Four quiet samples cover the pin synchroniser and the output register
  property p_tl_none; ({PINS.tl3, PINS.tl2, PINS.tl1} == 3'h0)[*4] |=> TORQUE_LIMIT == 16'h0064; endproperty
  a_tl_none: assert property (p_tl_none) else $error("torque limited with no input");
  property p_excl; !(FLAGS.shutoff && CURRENT_LIMIT != 16'h0064); endproperty
  a_excl: assert property (p_excl) else $error("current cap during shut-off");
  property p_shut_min; $rose(FLAGS.shutoff) |-> FLAGS.shutoff[*4]; endproperty
  a_shut_min: assert property (p_shut_min) else $error("shut-off too short");
  // Main scenarios reached
  c_shut: cover property ($rose(FLAGS.shutoff));
  c_dev: cover property ($rose(DEV_ALARM));
  c_ol: cover property ($rose(OL_ALARM));
endmodule
bind sdsv_top sdsv_asserts i_chk (.CLK, .RST_B, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_BVALID, .S_AXI_BREADY, .PINS, .SPEED_CMD, .SPEED_ACT, .EXC_REQ, .BASE_GAIN, .SPEED_CMD_OUT,
  .FLAGS, .TORQUE_LIMIT, .CURRENT_LIMIT, .EXC_RATE, .TOP_GAIN, .DEV_ALARM, .OL_ALARM);

// file: dv/sdsv_pin_model.sv
// Machine control switches feeding the general-purpose inputs
`timescale 1ns/100ps
module sdsv_pin_model (
  input wire logic CLK,
  input wire sdsv_pkg::sdsv_pins_t REQ,
  output sdsv_pkg::sdsv_pins_t PINS
);
  initial PINS = '0;
  // input levels held
  // Switches move 7 ns after each rising edge, so the synchroniser never samples a level as it changes
  always @(posedge CLK) begin
    PINS <= #7 REQ;
  end
endmodule

// file: dv/tb.sv
// Self-checking bench of the spindle drive supervision block
`timescale 1ns/100ps
module tb;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q, lf = 32'hb489e21c;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wrdy, bv, arr, rv, dev, ol, irq;
  logic [1:0] br, rr;
  logic [15:0] cmd = 16'h0, act = 16'h0, load = 16'h0, exc = 16'h0, base = 16'h0;
  logic [15:0] sco, tlim, clim, erate, tgain;
  sdsv_pkg::sdsv_pins_t req = '0, pins;
  sdsv_pkg::sdsv_flags_t flags;
  int err_count = 0, tests_run = 0, cyc = 0, i, j, m, n, v, d, det;
  int tl [2:7];
  int rst [20] = '{0, 30, 15, 20, 30, 40, 50, 60, 70, 12, 50, 7, 0, 150, 500, 75, 0, 60, 110, 100};
  int ta [7] = '{1000, 970, 969, 849, 1150, 1151, 850};
  int th [4] = '{0, 40, 20, 7};
  // Short ms and s so timers finish in tens of cycles
  sdsv_top #(.MS_CYCLES(4), .MS_PER_S(3)) i_dut (.CLK(CLK), .RST_B(RST_B),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(1'b1), .PINS(pins), .SPEED_CMD(cmd), .SPEED_ACT(act), .LOAD_PCT(load),
    .EXC_REQ(exc), .BASE_GAIN(base), .SPEED_CMD_OUT(sco), .FLAGS(flags), .TORQUE_LIMIT(tlim),
    .CURRENT_LIMIT(clim), .EXC_RATE(erate), .TOP_GAIN(tgain), .DEV_ALARM(dev), .OL_ALARM(ol), .IRQ(irq));
  sdsv_pin_model i_pins (.CLK(CLK), .REQ(req), .PINS(pins));
  // Clock and hang guard
  initial forever #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // Bench LFSR, Galois form
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Torque model: three-input combinations win over two-input ones
  function automatic int tq(input int md, input int p);
    if (md == 2 && p[2]) return tl[4 + p[1:0]];
    if (md > 0 && p[1]) return tl[2 + p[0]];
    return 100;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // AXI4-Lite write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [1:0] e);
    logic pa, pw;
    aw <= a;
    wd <= dd;
    awv <= 1'b1;
    wv <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge CLK);
      if (pa && awr === 1'b1) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wrdy === 1'b1) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge CLK);
    chk(br, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    ar <= a;
    arv <= 1'b1;
    @(posedge CLK);
    while (arr !== 1'b1) @(posedge CLK);
    arv <= 1'b0;
    @(posedge CLK);
    while (rv !== 1'b1) @(posedge CLK);
    q = rdat;
    chk(rr, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    tl = '{20, 30, 40, 50, 60, 70};
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    for (i = 0; i < 20; i++) begin
      rd(8'(i * 4), 2'h0);
      chk(q, rst[i]);
    end
    wr(8'h30, 32'h5, 2'h0);
    rd(8'h30, 2'h0);
    chk(q, 0);
    rd(8'h80, 2'h2);
    wr(8'h61, 32'h1, 2'h2);
    $display("test registers done");
    // Fresh limit four must act without any restart
    lf = nxt(lf);
    tl[4] = lf % 121;
    wr(8'h14, tl[4], 2'h0);
    for (m = 0; m < 3; m++) begin
      wr(8'h54, m, 2'h0);
      for (i = 0; i < 8; i++) begin
        req <= 4'(i);
        repeat (5) @(posedge CLK);
        chk(tlim, tq(m, i));
      end
    end
    req <= '0;
    $display("test torque done");
    for (i = 0; i < 8; i++) begin
      lf = nxt(lf);
      v = lf[15:0] % 101;
      d = lf[31:16] % 101;
      wr(8'h28, v, 2'h0);
      wr(8'h4c, d, 2'h0);
      lf = nxt(lf);
      exc <= lf[15:0] % 121;
      base <= lf[31:16];
      repeat (3) @(posedge CLK);
      chk(erate, (exc > v) ? exc : v);
      chk(tgain, base * d / 100);
    end
    $display("test excitation and gain done");
    wr(8'h50, 32'h3e8, 2'h0);
    cmd <= 16'h03e8;
    det = 0;
    foreach (ta[i]) begin
      act <= ta[i];
      repeat (3) @(posedge CLK);
      det = ta[i] >= 1000 ? 1 : (ta[i] + 30 < 1000 ? 0 : det);
      d = ta[i] - 1000;
      chk(flags.detect, det);
      chk(flags.reach, (d < 0 ? -d : d) * 100 <= 15 * 1000);
    end
    $display("test detect and reach done");
    foreach (th[i]) begin
      wr(8'h2c, th[i], 2'h0);
      v = th[i] ? th[i] : 12;
      for (j = 0; j < 2; j++) begin
        cmd <= 16'(cmd + v + j);
        act <= 16'(cmd + v + j);
        repeat (2) @(posedge CLK);
        chk(flags.accel, j);
        repeat (2) @(posedge CLK);
      end
    end
    wr(8'h00, 32'h1, 2'h0);
    cmd <= cmd + 16'h0064;
    act <= cmd + 16'h0064;
    repeat (4) @(posedge CLK);
    chk(sco < cmd, 1);
    repeat (120) @(posedge CLK);
    chk(sco, cmd);
    wr(8'h00, 32'h0, 2'h0);
    $display("test command shaping done");
    // Changeover with short timers, its end event unmasked
    wr(8'h34, 32'h2, 2'h0);
    wr(8'h38, 32'h3, 2'h0);
    lf = nxt(lf);
    v = lf % 100;
    wr(8'h3c, v, 2'h0);
    wr(8'h5c, 32'h4, 2'h0);
    req.chg_req <= 1'b1;
    n = 0;
    m = 0;
    while (flags.shutoff !== 1'b1) @(posedge CLK);
    while (flags.shutoff === 1'b1) begin
      @(posedge CLK);
      n++;
    end
    chk(n >= 2 * 4 && n <= 3 * 4, 1);
    while (clim === 16'(v)) begin
      @(posedge CLK);
      m++;
    end
    chk(m, 12);
    chk(clim, 100);
    repeat (2) @(posedge CLK);
    chk(irq, 1);
    wr(8'h58, 32'h4, 2'h0);
    wr(8'h5c, 32'h0, 2'h0);
    req.chg_req <= 1'b0;
    chk(irq, 0);
    $display("test changeover done");
    wr(8'h24, 32'h2, 2'h0);
    act <= 16'h0;
    n = 0;
    while (dev !== 1'b1) begin
      @(posedge CLK);
      n++;
    end
    chk(n >= 11 && n <= 28, 1);
    rd(8'h58, 2'h0);
    chk(q[0], 1);
    chk(irq, 0);
    act <= cmd;
    wr(8'h54, 32'h6, 2'h0);
    repeat (2) @(posedge CLK);
    chk(dev, 0);
    $display("test deviation done");
    wr(8'h44, 32'h2, 2'h0);
    load <= 16'h006f;
    n = 0;
    while (ol !== 1'b1) begin
      @(posedge CLK);
      n++;
    end
    chk(n >= 11 && n <= 40, 1);
    load <= 16'h006e;
    repeat (2) @(posedge CLK);
    chk(ol, 1);
    wr(8'h54, 32'h6, 2'h0);
    repeat (2) @(posedge CLK);
    chk(ol, 0);
    $display("test overload done");
    finish_test();
  end
endmodule
